// ---- msr_regs.svh ----
// Purpose: Offsets, field positions and reset values of the special register bank
// Assumes: Registers are selected by their printed index
// Notes:   Definitions only
`ifndef MSR_REGS_SVH
`define MSR_REGS_SVH

`define MSR_IDX_LINE_SIZE   12'h006
`define MSR_IDX_CYCLE       12'h010
`define MSR_IDX_PLATFORM    12'h017
`define MSR_IDX_ICTRL_BASE  12'h01B
`define MSR_IDX_POWERON     12'h02A

`define MSR_LINE_SIZE_RST   16'h0040
`define MSR_LINE_HI         15
`define MSR_PLAT_LO         50
`define MSR_PLAT_HI         52
`define MSR_BOOT_BIT        8
`define MSR_GEN_BIT         11
`define MSR_BASE_LO         12
`define MSR_BASE_HI         31
`define MSR_BASE_RST        20'hFEE00
`define MSR_CYC_HALF        32
`define MSR_FAMILY_NEW      8'h0F
`define MSR_MODEL_A         8'h03
`define MSR_MODEL_B         8'h04
`define MSR_PWR_WR_MASK     64'h0000_0000_0000_0000

`endif

// ---- msr_pkg.sv ----
// Purpose: Types shared by the special register bank
// Assumes: Constants live in msr_regs.svh
// Notes:   Access kinds only
package msr_pkg;
  typedef enum logic [1:0] {
    MSR_ACC_IDLE,
    MSR_ACC_READ,
    MSR_ACC_WRITE
  } msr_acc_t;
endpackage

// ---- msr_cycle_counter.sv ----
// Purpose: Free-running 64-bit cycle counter with model-dependent writes
// Assumes: Write strobe is one cycle wide
// Notes:   Write takes precedence over increment in its cycle
`include "msr_regs.svh"

module msr_cycle_counter (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic        full_width,
  input  wire logic [63:0] wr_data,
  output logic      [63:0] count
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 64'h0;
    end else if (wr_en && full_width) begin
      count <= wr_data;
    end else if (wr_en) begin
      count <= {32'h0, wr_data[`MSR_CYC_HALF-1:0]};
    end else begin
      count <= count + 64'h1;
    end
  end
endmodule

// ---- msr_bank.sv ----
// Purpose: Bank of model-specific configuration and status registers
// Assumes: One access per cycle from the special register instruction unit
// Notes:   Read data is registered and valid one cycle after the request
`include "msr_regs.svh"

// Notes on behaviour
// - Monitor line-size field is bits 15:0, resets to 40H meaning 64 bytes.
// - Line-size value sets monitor semaphore spacing and alignment.
// - Cycle counter is one 64-bit quantity via read, write, counter-read.
// - Reading the cycle counter returns the present count, all 64 bits.
// - Older models accept counter writes only into the lower 32 bits.
// - On older models, a low write also clears the upper 32 bits.
// - Family 0FH models 3 and 4 allow writing all 64 counter bits.
// - Platform identifier is read-only bits 52:50; other bits reserved.
// - Interrupt-controller base bit 8 reads one on the bootstrap processor.
// - Base bit 11 shows the controller global enable.
// - Base bits 31:12 hold the controller's register space base address.
// - Power-on register: writable fields enable features, read fields report; MSR_PWR_WR_MASK is zero here, so no field is writable.
module msr_bank
  import msr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        acc_rd,
  input  wire logic        acc_wr,
  input  wire logic        cnt_rd,
  input  wire logic [11:0] acc_index,
  input  wire logic [63:0] acc_wdata,
  input  wire logic [7:0]  cpu_family,
  input  wire logic [7:0]  cpu_model,
  input  wire logic [2:0]  platform_strap,
  input  wire logic        bootstrap_processor_flag,
  input  wire logic [63:0] poweron_status,
  output logic      [63:0] acc_rdata,
  output logic             acc_valid,
  output logic             acc_fault,
  output logic      [15:0] monitor_line_size,
  output logic      [63:0] monitor_align_mask,
  output logic             ictrl_enable,
  output logic      [19:0] ictrl_base,
  output logic      [63:0] poweron_ctrl
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] idx);
    is_mapped = (idx == `MSR_IDX_LINE_SIZE) || (idx == `MSR_IDX_CYCLE) ||
                (idx == `MSR_IDX_PLATFORM) || (idx == `MSR_IDX_ICTRL_BASE) ||
                (idx == `MSR_IDX_POWERON);
  endfunction

  msr_acc_t    acc_kind;
  logic        wr_line;
  logic        wr_cycle;
  logic        wr_base;
  logic        wr_pwr;
  logic        cyc_full;
  logic [63:0] cycle_count;
  logic [2:0]  platform_identity;
  logic        boot_seen;
  logic [63:0] next_rdata;

  always_comb begin
    if (acc_wr) begin
      acc_kind = MSR_ACC_WRITE;
    end else if (acc_rd || cnt_rd) begin
      acc_kind = MSR_ACC_READ;
    end else begin
      acc_kind = MSR_ACC_IDLE;
    end
  end

  assign wr_line  = (acc_kind == MSR_ACC_WRITE) && (acc_index == `MSR_IDX_LINE_SIZE);
  assign wr_cycle = (acc_kind == MSR_ACC_WRITE) && (acc_index == `MSR_IDX_CYCLE);
  assign wr_base  = (acc_kind == MSR_ACC_WRITE) && (acc_index == `MSR_IDX_ICTRL_BASE);
  assign wr_pwr   = (acc_kind == MSR_ACC_WRITE) && (acc_index == `MSR_IDX_POWERON);
  assign cyc_full = (cpu_family == `MSR_FAMILY_NEW) &&
                    ((cpu_model == `MSR_MODEL_A) || (cpu_model == `MSR_MODEL_B));

  // ---------------------------------------------------------------
  // Cycle counter
  // ---------------------------------------------------------------
  msr_cycle_counter u_cycle (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .wr_en      (wr_cycle),
    .full_width (cyc_full),
    .wr_data    (acc_wdata),
    .count      (cycle_count)
  );

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      monitor_line_size <= `MSR_LINE_SIZE_RST;
    end else if (wr_line) begin
      monitor_line_size <= acc_wdata[`MSR_LINE_HI:0];
    end
  end

  // Mask of address bits inside one monitored line; exact for power-of-two sizes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      monitor_align_mask <= {48'h0, `MSR_LINE_SIZE_RST - 16'h1};
    end else begin
      monitor_align_mask <= {48'h0, monitor_line_size - 16'h1};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ictrl_enable <= 1'b1;
      ictrl_base   <= `MSR_BASE_RST;
    end else if (wr_base) begin
      ictrl_enable <= acc_wdata[`MSR_GEN_BIT];
      ictrl_base   <= acc_wdata[`MSR_BASE_HI:`MSR_BASE_LO];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      poweron_ctrl <= 64'h0;
    end else if (wr_pwr) begin
      poweron_ctrl <= acc_wdata & `MSR_PWR_WR_MASK;
    end
  end

  // Straps are captured after reset release, never inside the reset branch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_seen         <= 1'b0;
      platform_identity <= 3'h0;
    end else begin
      boot_seen         <= bootstrap_processor_flag;
      platform_identity <= platform_strap;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 64'h0;
    if (cnt_rd && !acc_wr) begin
      next_rdata = cycle_count;
    end else begin
      unique case (acc_index)
        `MSR_IDX_LINE_SIZE:  next_rdata[`MSR_LINE_HI:0] = monitor_line_size;
        `MSR_IDX_CYCLE:      next_rdata = cycle_count;
        `MSR_IDX_PLATFORM:   next_rdata[`MSR_PLAT_HI:`MSR_PLAT_LO] = platform_identity;
        `MSR_IDX_ICTRL_BASE: begin
          next_rdata[`MSR_BOOT_BIT]                = boot_seen;
          next_rdata[`MSR_GEN_BIT]                 = ictrl_enable;
          next_rdata[`MSR_BASE_HI:`MSR_BASE_LO]    = ictrl_base;
        end
        `MSR_IDX_POWERON:    next_rdata = (poweron_status & ~`MSR_PWR_WR_MASK) |
                                          poweron_ctrl;
        default:             next_rdata = 64'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_rdata <= 64'h0;
      acc_valid <= 1'b0;
      acc_fault <= 1'b0;
    end else begin
      acc_valid <= (acc_kind != MSR_ACC_IDLE);
      acc_fault <= (acc_kind != MSR_ACC_IDLE) && !(cnt_rd && !acc_wr) &&
                   !is_mapped(acc_index);
      acc_rdata <= (acc_kind == MSR_ACC_READ) ? next_rdata : 64'h0;
    end
  end

endmodule

// ---- msr_bank_chk.sv ----
// Purpose: Port assertions for the special register bank
// Assumes: Answer comes one cycle after the request edge
// Notes:   Bound from the bench top file
module msr_bank_chk (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        acc_rd,
  input wire logic        acc_wr,
  input wire logic        cnt_rd,
  input wire logic [11:0] acc_index,
  input wire logic [63:0] acc_wdata,
  input wire logic [63:0] acc_rdata,
  input wire logic        acc_valid,
  input wire logic        acc_fault,
  input wire logic [15:0] monitor_line_size,
  input wire logic        ictrl_enable,
  input wire logic [19:0] ictrl_base
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rq;
  assign rq = acc_rd & ~acc_wr & ~cnt_rd;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_answer_next: assert property (
    (acc_rd | acc_wr | cnt_rd) |=> acc_valid) else $error("no answer");
  a_write_quiet: assert property (
    acc_wr && (acc_index inside {12'h006, 12'h010, 12'h017, 12'h01B, 12'h02A})
    |=> acc_rdata == 64'h0 && !acc_fault) else $error("write answered data");
  a_line_read: assert property (
    rq && acc_index == 12'h006 |=> acc_rdata == {48'h0, $past(monitor_line_size)})
    else $error("line read");
  a_line_write: assert property (
    acc_wr && acc_index == 12'h006 |=> monitor_line_size == $past(acc_wdata[15:0]))
    else $error("line write");
  a_plat_resv: assert property (
    rq && acc_index == 12'h017 |=> acc_rdata[63:53] == 11'h0 && acc_rdata[49:0] == 50'h0)
    else $error("platform spare bits");
  a_base_read: assert property (
    rq && acc_index == 12'h01B |=> acc_rdata[63:32] == 32'h0 && acc_rdata[7:0] == 8'h0
    && acc_rdata[31:9] == {$past(ictrl_base), $past(ictrl_enable), 2'b0})
    else $error("base read");
  a_base_write: assert property (
    acc_wr && acc_index == 12'h01B |=> ictrl_base == $past(acc_wdata[31:12])
    && ictrl_enable == $past(acc_wdata[11])) else $error("base write");
  a_fault_map: assert property (
    rq && !(acc_index inside {12'h006, 12'h010, 12'h017, 12'h01B, 12'h02A})
    |=> acc_fault && acc_rdata == 64'h0) else $error("unmapped");
endmodule

// ---- msr_bank_tb_top.sv ----
// Purpose: Self-checking bench for the special register bank
// Assumes: Answer one cycle after the request edge
// Notes:   Random data from a fixed-seed shift register
module msr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, acc_rd, acc_wr, cnt_rd, bootstrap_processor_flag;
  logic        acc_valid, acc_fault;
  logic [11:0] acc_index;
  logic [63:0] acc_wdata, acc_rdata, poweron_status, v, d, e, w_v, align_mask, pwr_ctl;
  logic [7:0]  cpu_family, cpu_model;
  logic [2:0]  platform_strap;
  logic [15:0] w;
  logic [31:0] seed;
  int          mismatches, checks;
  msr_bank dut (.core_clk, .rstn, .acc_rd, .acc_wr, .cnt_rd, .acc_index, .acc_wdata,
    .cpu_family, .cpu_model, .platform_strap, .bootstrap_processor_flag, .poweron_status,
    .acc_rdata, .acc_valid, .acc_fault, .monitor_line_size(), .monitor_align_mask(align_mask),
    .ictrl_enable(), .ictrl_base(), .poweron_ctrl(pwr_ctl));
  function automatic logic [63:0] exp_cnt(input logic [63:0] x, input logic full);
    return full ? x : {32'h0, x[31:0]};
  endfunction
  function automatic logic [63:0] exp_base(input logic [19:0] b, input logic en, bs);
    return {32'h0, b, en, 2'b0, bs, 8'h0};
  endfunction
  function automatic logic [63:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed, ~seed ^ {seed[15:0], seed[31:16]}};
  endfunction
  task automatic chk(input string n, input logic [63:0] ev, sv);
    checks++;
    if (sv !== ev) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, ev, sv);
    end
  endtask
  task automatic op(input logic r, wr, c, input logic [11:0] i, input logic [63:0] dv);
    @(posedge core_clk);
    acc_rd    <= r;
    acc_wr    <= wr;
    cnt_rd    <= c;
    acc_index <= i;
    acc_wdata <= dv;
  endtask
  task automatic get(output logic [63:0] q);
    @(posedge core_clk);
    acc_rd <= 1'b0;
    acc_wr <= 1'b0;
    cnt_rd <= 1'b0;
    #1;
    q = acc_rdata;
    chk("valid", 64'h1, {63'h0, acc_valid});
  endtask
  task automatic rd(input logic [11:0] i);
    op(1'b1, 1'b0, 1'b0, i, 64'h0);
    get(v);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
  initial begin
    {rstn, acc_rd, acc_wr, cnt_rd, acc_index, acc_wdata} = '0;
    {cpu_family, cpu_model, platform_strap, bootstrap_processor_flag} = {16'h0603, 4'h5};
    seed = 32'hD423;
    poweron_status = rnd();
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(12'h006);
    chk("line", 64'h40, v);
    rd(12'h01B);
    chk("base", exp_base(20'hFEE00, 1'b1, 1'b1), v);
    rd(12'h123);
    chk("fault", 64'h1, {63'h0, acc_fault});
    for (int n = 0; n < 8; n++) begin
      d = rnd();
      e = rnd();
      cpu_family <= (n < 6) ? 8'h0F : 8'h0E;
      cpu_model <= 8'(n);
      platform_strap <= e[2:0];
      bootstrap_processor_flag <= e[9];
      poweron_status <= e;
      op(1'b0, 1'b1, 1'b0, 12'h010, d);
      op(1'b0, 1'b0, 1'b1, 12'h000, 64'h0);
      get(v);
      chk("count", exp_cnt(d, n == 3 || n == 4), v);
      op(1'b0, 1'b0, 1'b1, 12'h017, 64'h0);
      get(w_v);
      chk("tick", v + 64'h2, w_v);
      w = (d[15:0] > e[15:0]) ? d[15:0] : e[15:0];
      op(1'b0, 1'b1, 1'b0, 12'h006, {d[63:16], w});
      rd(12'h006);
      chk("line", {48'h0, w}, v);
      chk("align", {48'h0, w - 16'h1}, align_mask);
      op(1'b0, 1'b1, 1'b0, 12'h01B, d);
      rd(12'h01B);
      chk("base", exp_base(d[31:12], d[11], e[9]), v);
      op(1'b0, 1'b1, 1'b0, 12'h017, d);
      rd(12'h017);
      chk("plat", {11'h0, e[2:0], 50'h0}, v);
      op(1'b0, 1'b1, 1'b0, 12'h02A, d);
      rd(12'h02A);
      chk("poweron", e, v);
      chk("pwrctl", 64'h0, pwr_ctl);
    end
    complete_run();
  end
endmodule
bind msr_bank msr_bank_chk u_chk (.core_clk, .rstn, .acc_rd, .acc_wr, .cnt_rd, .acc_index,
  .acc_wdata, .acc_rdata, .acc_valid, .acc_fault, .monitor_line_size, .ictrl_enable,
  .ictrl_base);
